// file: design/cfpc_params.svh
// Constants for the current filter and path control block: register indexes,
// field positions and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CFPC_PARAMS_SVH
`define CFPC_PARAMS_SVH

// ==========================================================================
// Register map (word index; byte address is four times the index)
`define CFPC_CTRL_IDX 8'h07
`define CFPC_STAT_IDX 8'h08
`define CFPC_BAD_IDX 8'hFF
`define CFPC_CTRL_RST 8'h04

// ==========================================================================
// Control register fields
`define CFPC_SEL_BIT 7
`define CFPC_CNT_HI 6
`define CFPC_CNT_LO 3
`define CFPC_PATH_HI 2
`define CFPC_PATH_LO 1
`define CFPC_PATH_RST 2'h2

// ==========================================================================
// Status register fields
`define CFPC_STAT_MA_BIT 0
`define CFPC_STAT_FILL_HI 4
`define CFPC_STAT_FILL_LO 1
`define CFPC_STAT_PATH_HI 6
`define CFPC_STAT_PATH_LO 5

// ==========================================================================
// Stream and averaging sizes
`define CFPC_SAMPLE_W 16
`define CFPC_HIST_DEPTH 15
`define CFPC_SUM_W 20

`endif

// file: design/cfpc_pkg.sv
// Types shared by the current filter and path control modules.
// Assumes cfpc_params.svh is on the include path.
`include "cfpc_params.svh"

package cfpc_pkg;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic signed [`CFPC_SAMPLE_W-1:0] data;
    } cfpc_strm_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } cfpc_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } cfpc_ahb_rsp_t;

    typedef enum logic [1:0] {
        CFPC_DEMOD_AFTER = 2'h0,
        CFPC_DEMOD_BEFORE = 2'h1,
        CFPC_DECHOP_AFTER = 2'h2,
        CFPC_DEMOD_SETTLED = 2'h3
    } cfpc_path_t;

    // ======================================================================
    // Module state
    typedef struct packed {
        logic [`CFPC_HIST_DEPTH-1:0][`CFPC_SAMPLE_W-1:0] hist;
        logic [3:0] fill;
        cfpc_strm_t out;
    } cfpc_avg_st_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
        cfpc_strm_t out;
    } cfpc_top_st_t;

endpackage

// file: design/cfpc_avg.sv
// Moving-average filter for the current channel with selectable length.
// Assumes samples arrive on the module clock, at most one per cycle.
`timescale 1ns/10ps
`include "cfpc_params.svh"

module cfpc_avg (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] count_in,
    input wire logic clear_in,
    input cfpc_pkg::cfpc_strm_t din_in,
    output cfpc_pkg::cfpc_strm_t dout_out,
    output logic [3:0] fill_out
);
    import cfpc_pkg::*;

    cfpc_avg_st_t st_q;
    cfpc_avg_st_t st_d;
    logic signed [`CFPC_SUM_W-1:0] sum;
    logic signed [`CFPC_SUM_W-1:0] quot;

    // ======================================================================
    // Next state
    // History not yet filled counts as zero, so the first results after a
    // length change ramp up rather than jump.
    always_comb
    begin
        st_d = st_q;
        sum = '0;
        quot = '0;
        st_d.out.valid = 1'b0;
        if (clear_in)
        begin
            st_d.hist = '0;
            st_d.fill = 4'h0;
        end
        else if (din_in.valid)
        begin
            st_d.hist = {st_q.hist[`CFPC_HIST_DEPTH-2:0], din_in.data};
            if (st_q.fill < count_in)
            begin
                st_d.fill = st_q.fill + 4'h1;
            end
            for (int i = 0; i < `CFPC_HIST_DEPTH; i++)
            begin
                if (i < count_in)
                begin
                    sum = sum + `CFPC_SUM_W'($signed(st_d.hist[i]));
                end
            end
            if (count_in == 4'h0)
            begin
                st_d.out.data = din_in.data;
            end
            else
            begin
                quot = sum / $signed({1'b0, count_in});
                st_d.out.data = quot[`CFPC_SAMPLE_W-1:0];
            end
            st_d.out.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign dout_out = st_q.out;
    assign fill_out = st_q.fill;

    a_single_mean: assert property (
        @(posedge clk_in) disable iff (rst_in)
        din_in.valid && !clear_in && count_in == 4'h1
        |=> dout_out.valid && dout_out.data == $past(din_in.data))
    else $error("Length-one average does not equal the newest sample.");

endmodule

// file: design/cfpc_top.sv
// Current-channel post-decimation filter selection and measurement-path
// control, with its control register on an AHB-Lite slave port.
// Assumes the FIR result and the CIC2 samples arrive on CLOCK_IN.
`timescale 1ns/10ps
`include "cfpc_params.svh"

module cfpc_top (
    input wire logic CLOCK_IN,
    input wire logic RESET_IN,
    input cfpc_pkg::cfpc_ahb_req_t AHB_REQ_IN,
    output cfpc_pkg::cfpc_ahb_rsp_t AHB_RSP_OUT,
    input cfpc_pkg::cfpc_strm_t CIC_STREAM_IN,
    input cfpc_pkg::cfpc_strm_t FIR_STREAM_IN,
    output cfpc_pkg::cfpc_strm_t FILT_STREAM_OUT,
    output cfpc_pkg::cfpc_path_t PATH_SEL_OUT
);
    import cfpc_pkg::*;

    cfpc_top_st_t st_q;
    cfpc_top_st_t st_d;

    logic take;
    logic [7:0] take_idx;
    logic ctrl_wr;
    logic [7:0] ctrl_view;
    logic [31:0] stat_word;
    logic cnt_change;
    cfpc_strm_t avg_out;
    logic [3:0] avg_fill;

    // ======================================================================
    // Bus address phase
    // The slave never inserts wait states, so the bus hready alone decides
    // whether an address phase is accepted. Only the low word index is
    // decoded; any set bit outside it marks the access as unmapped.
    always_comb
    begin
        take = AHB_REQ_IN.hsel && AHB_REQ_IN.htrans[1] && AHB_REQ_IN.hready;
        if (AHB_REQ_IN.haddr[31:10] == 22'h0 && AHB_REQ_IN.haddr[1:0] == 2'h0)
        begin
            take_idx = AHB_REQ_IN.haddr[9:2];
        end
        else
        begin
            take_idx = `CFPC_BAD_IDX;
        end
    end

    // ======================================================================
    // Write data phase and read forwarding
    // A control register read that directly follows a write to it sees the
    // new value, because its read data is taken from the bus write data while
    // that write is still in its data phase.
    always_comb
    begin
        ctrl_wr = st_q.wr_pend && st_q.wr_idx == `CFPC_CTRL_IDX;
        if (ctrl_wr)
        begin
            ctrl_view = AHB_REQ_IN.hwdata[7:0];
        end
        else
        begin
            ctrl_view = st_q.ctrl;
        end
        cnt_change = ctrl_wr &&
            (ctrl_view[`CFPC_CNT_HI:`CFPC_CNT_LO] != st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO]);
    end

    // ======================================================================
    // Status word
    always_comb
    begin
        stat_word = 32'h0000_0000;
        stat_word[`CFPC_STAT_MA_BIT] = st_q.ctrl[`CFPC_SEL_BIT];
        stat_word[`CFPC_STAT_FILL_HI:`CFPC_STAT_FILL_LO] = avg_fill;
        stat_word[`CFPC_STAT_PATH_HI:`CFPC_STAT_PATH_LO] =
            st_q.ctrl[`CFPC_PATH_HI:`CFPC_PATH_LO];
    end

    // ======================================================================
    // Moving-average filter
    // Changing the length flushes the history so a new window never mixes
    // with samples weighted for the old one.
    cfpc_avg u_avg (
        .clk_in(CLOCK_IN),
        .rst_in(RESET_IN),
        .count_in(st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO]),
        .clear_in(cnt_change),
        .din_in(CIC_STREAM_IN),
        .dout_out(avg_out),
        .fill_out(avg_fill)
    );

    // ======================================================================
    // Next state
    always_comb
    begin
        st_d = st_q;

        // The reserved bit is stored as written; nothing inside reads it.
        if (ctrl_wr)
        begin
            st_d.ctrl = AHB_REQ_IN.hwdata[7:0];
        end

        st_d.wr_pend = take && AHB_REQ_IN.hwrite;
        st_d.wr_idx = take_idx;

        if (take && !AHB_REQ_IN.hwrite)
        begin
            case (take_idx)
                `CFPC_CTRL_IDX:
                begin
                    st_d.rdata = {24'h00_0000, ctrl_view};
                end
                `CFPC_STAT_IDX:
                begin
                    st_d.rdata = stat_word;
                end
                default:
                begin
                    st_d.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Output keeps its last sample while no new one is valid.
        st_d.out.valid = 1'b0;
        if (!st_q.ctrl[`CFPC_SEL_BIT])
        begin
            if (FIR_STREAM_IN.valid)
            begin
                st_d.out = FIR_STREAM_IN;
            end
        end
        else
        begin
            if (avg_out.valid)
            begin
                st_d.out = avg_out;
            end
        end
    end

    // ======================================================================
    // State register
    always_ff @(posedge CLOCK_IN or posedge RESET_IN)
    begin
        if (RESET_IN)
        begin
            st_q.ctrl <= `CFPC_CTRL_RST;
            st_q.wr_pend <= 1'b0;
            st_q.wr_idx <= `CFPC_BAD_IDX;
            st_q.rdata <= 32'h0000_0000;
            st_q.out <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ======================================================================
    // Outputs
    assign AHB_RSP_OUT.hrdata = st_q.rdata;
    assign AHB_RSP_OUT.hreadyout = 1'b1;
    assign AHB_RSP_OUT.hresp = 1'b0;
    assign FILT_STREAM_OUT = st_q.out;
    assign PATH_SEL_OUT = cfpc_path_t'(st_q.ctrl[`CFPC_PATH_HI:`CFPC_PATH_LO]);

    // ======================================================================
    // Checks
    a_fir_route: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        !st_q.ctrl[`CFPC_SEL_BIT] && FIR_STREAM_IN.valid
        |=> FILT_STREAM_OUT.valid && FILT_STREAM_OUT.data == $past(FIR_STREAM_IN.data))
    else $error("FIR sample not forwarded with filter select low.");

    a_ma_bypass: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        st_q.ctrl[`CFPC_SEL_BIT] && st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO] == 4'h0 &&
        !ctrl_wr && CIC_STREAM_IN.valid
        ##1 st_q.ctrl[`CFPC_SEL_BIT]
        |=> FILT_STREAM_OUT.valid && FILT_STREAM_OUT.data == $past(CIC_STREAM_IN.data, 2))
    else $error("Bypassed average did not pass the sample in two cycles.");

    a_path_write: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        ctrl_wr
        |=> PATH_SEL_OUT == $past(AHB_REQ_IN.hwdata[`CFPC_PATH_HI:`CFPC_PATH_LO]))
    else $error("Path select does not follow the written code.");

    a_path_reset: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        $past(RESET_IN) && !RESET_IN
        |-> PATH_SEL_OUT == CFPC_DECHOP_AFTER && !st_q.ctrl[`CFPC_SEL_BIT])
    else $error("Path select is not the dechopper arrangement after reset.");

    a_fir_hold: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        !st_q.ctrl[`CFPC_SEL_BIT] && !FIR_STREAM_IN.valid
        |=> !FILT_STREAM_OUT.valid && $stable(FILT_STREAM_OUT.data))
    else $error("Output changed without a valid FIR sample.");

    // ======================================================================
    // Register and average checks
    // These watch the average from outside, so a change to its internals is
    // still held against what the control register asks for.
    a_ma_route: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        st_q.ctrl[`CFPC_SEL_BIT] && avg_out.valid
        |=> FILT_STREAM_OUT.valid && FILT_STREAM_OUT.data == $past(avg_out.data))
    else $error("Average result not forwarded with filter select high.");

    a_ma_hold: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        st_q.ctrl[`CFPC_SEL_BIT] && !avg_out.valid
        |=> !FILT_STREAM_OUT.valid && $stable(FILT_STREAM_OUT.data))
    else $error("Output changed without an average result.");

    a_sel_write: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        ctrl_wr
        |=> st_q.ctrl[`CFPC_SEL_BIT] == $past(AHB_REQ_IN.hwdata[`CFPC_SEL_BIT]))
    else $error("Filter select does not follow the written bit.");

    a_stat_select: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        take && !AHB_REQ_IN.hwrite && take_idx == `CFPC_STAT_IDX
        |=> AHB_RSP_OUT.hrdata[`CFPC_STAT_MA_BIT] == $past(st_q.ctrl[`CFPC_SEL_BIT]))
    else $error("Status read does not show the filter select.");

    a_count_write: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        ctrl_wr
        |=> st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO] ==
            $past(AHB_REQ_IN.hwdata[`CFPC_CNT_HI:`CFPC_CNT_LO]))
    else $error("Averaging count does not follow the written field.");

    a_bypass_pass: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        CIC_STREAM_IN.valid && !cnt_change && st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO] == 4'h0
        |=> avg_out.valid && avg_out.data == $past(CIC_STREAM_IN.data))
    else $error("Bypassed average changed the sample.");

    a_ctrl_hold: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        !ctrl_wr
        |=> $stable(st_q.ctrl))
    else $error("Control register changed without a write.");

    a_path_hold: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        !ctrl_wr
        |=> $stable(PATH_SEL_OUT))
    else $error("Path select changed without a write.");

    a_read_ctrl: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        take && !AHB_REQ_IN.hwrite && take_idx == `CFPC_CTRL_IDX
        |=> AHB_RSP_OUT.hrdata == {24'h00_0000, $past(ctrl_view)})
    else $error("Control read does not return the current setting.");

    a_stat_path: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        take && !AHB_REQ_IN.hwrite && take_idx == `CFPC_STAT_IDX
        |=> AHB_RSP_OUT.hrdata[`CFPC_STAT_PATH_HI:`CFPC_STAT_PATH_LO] ==
            $past(st_q.ctrl[`CFPC_PATH_HI:`CFPC_PATH_LO]))
    else $error("Status read does not show the path code.");

    a_ctrl_reset: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        $past(RESET_IN) && !RESET_IN
        |-> st_q.ctrl == `CFPC_CTRL_RST)
    else $error("Control register is not at its reset value after reset.");

    a_clear_fill: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        cnt_change
        |=> avg_fill == 4'h0)
    else $error("A new averaging count did not flush the window.");

    a_fill_bound: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        1'b1
        |-> avg_fill <= st_q.ctrl[`CFPC_CNT_HI:`CFPC_CNT_LO])
    else $error("Average window holds more samples than the count.");

    a_avg_valid: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        CIC_STREAM_IN.valid && !cnt_change
        |=> avg_out.valid)
    else $error("Average gave no result for an input sample.");

    a_avg_idle: assert property (
        @(posedge CLOCK_IN) disable iff (RESET_IN)
        !CIC_STREAM_IN.valid
        |=> !avg_out.valid)
    else $error("Average gave a result without an input sample.");

endmodule

// file: test/cfpc_top_test.sv
// Self-checking bench for the current filter and path control block.
// Assumes the design package, its header and cfpc_top are compiled first.
`timescale 1ns/10ps
`include "cfpc_params.svh"

module cfpc_top_test;
    import cfpc_pkg::*;

    logic clk;
    logic rst;
    cfpc_ahb_req_t drv;
    cfpc_ahb_req_t req;
    cfpc_ahb_rsp_t rsp;
    cfpc_strm_t cic;
    cfpc_strm_t fir;
    cfpc_strm_t filt;
    cfpc_path_t path;
    int err_count;
    int n_compared;
    logic [31:0] rd;
    logic [15:0] q[$];
    logic [15:0] expq[$];
    logic signed [15:0] hist[15];
    int sum;
    int cnts[4] = '{1, 3, 7, 15};

    // ======================================================================
    // Clock, stimulus defaults and design
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        drv = '0;
        cic = '0;
        fir = '0;
    end

    // The single slave's ready is the bus ready.
    always_comb
    begin
        req = drv;
        req.hready = rsp.hreadyout;
    end

    cfpc_top DUT (
        .CLOCK_IN(clk),
        .RESET_IN(rst),
        .AHB_REQ_IN(req),
        .AHB_RSP_OUT(rsp),
        .CIC_STREAM_IN(cic),
        .FIR_STREAM_IN(fir),
        .FILT_STREAM_OUT(filt),
        .PATH_SEL_OUT(path)
    );

    always @(posedge clk)
    begin
        if (filt.valid === 1'b1)
            q.push_back(filt.data);
    end

    // ======================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Both tasks start just after an edge and end at the edge closing the data phase.
    task automatic ahb_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] val);
        drv.hsel <= 1'b1;
        drv.haddr <= {22'h00_0000, idx, 2'h0};
        drv.htrans <= 2'h2;
        drv.hwrite <= wr;
        drv.hsize <= 3'h2;
        @(posedge clk);
        while (rsp.hreadyout !== 1'b1)
            @(posedge clk);
        drv.htrans <= 2'h0;
        drv.hwdata <= {24'h00_0000, val};
        @(posedge clk);
        while (rsp.hreadyout !== 1'b1)
            @(posedge clk);
        rd = rsp.hrdata;
    endtask

    task automatic ahb_wr(input logic [7:0] idx, input logic [7:0] val);
        ahb_xfer(1'b1, idx, val);
    endtask

    task automatic ahb_rd(input logic [7:0] idx);
        ahb_xfer(1'b0, idx, 8'h00);
    endtask

    task automatic feed(input logic to_fir, input logic [15:0] d);
        fir.valid <= to_fir;
        cic.valid <= ~to_fir;
        fir.data <= d;
        cic.data <= d;
        @(posedge clk);
    endtask

    task automatic stop_feed();
        fir.valid <= 1'b0;
        cic.valid <= 1'b0;
    endtask

    task automatic give_verdict();
        $display("Comparisons: %0d, mismatches: %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ======================================================================
    // Tests
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({30'h0000_0000, path}, 32'h0000_0002);
        ahb_rd(`CFPC_CTRL_IDX);
        check(rd, 32'h0000_0004);
        ahb_rd(`CFPC_STAT_IDX);
        check({rsp.hresp, rd[30:0]}, 32'h0000_0040);
        ahb_wr(`CFPC_BAD_IDX, 8'hFF);
        ahb_wr(`CFPC_STAT_IDX, 8'hFE);
        ahb_rd(`CFPC_BAD_IDX);
        check(rd, 32'h0000_0000);
        ahb_rd(`CFPC_CTRL_IDX);
        check(rd, 32'h0000_0004);
        // Reserved bit 0 is always written as 0.
        for (int p = 0; p < 4; p++)
        begin
            ahb_wr(`CFPC_CTRL_IDX, 8'(p << 1));
            ahb_rd(`CFPC_CTRL_IDX);
            check(rd, 32'(p << 1));
            check({30'h0000_0000, path}, 32'(p));
        end
        feed(1'b1, 16'h8001);
        stop_feed();
        @(posedge clk);
        check({31'h0000_0000, filt.valid}, 32'h0000_0001);
        check({16'h0000, filt.data}, 32'h0000_8001);
        // Let the monitor take the last result before its queue is emptied.
        @(posedge clk);
        q.delete();
        feed(1'b0, 16'h1234);
        stop_feed();
        repeat (5) @(posedge clk);
        check(32'(q.size()), 32'h0000_0000);
        ahb_wr(`CFPC_CTRL_IDX, 8'h84);
        feed(1'b0, 16'hF00D);
        stop_feed();
        @(posedge clk);
        @(posedge clk);
        check({31'h0000_0000, filt.valid}, 32'h0000_0001);
        check({16'h0000, filt.data}, 32'h0000_F00D);
        @(posedge clk);
        q.delete();
        feed(1'b1, 16'h5555);
        stop_feed();
        repeat (5) @(posedge clk);
        check(32'(q.size()), 32'h0000_0000);
        // A new count flushes the window, so unfilled slots count as zero.
        foreach (cnts[c])
        begin
            ahb_wr(`CFPC_CTRL_IDX, 8'(8'h84 | (cnts[c] << 3)));
            q.delete();
            expq.delete();
            foreach (hist[j])
                hist[j] = 16'sh0000;
            for (int k = 0; k < cnts[c] + 2; k++)
            begin
                for (int j = 14; j > 0; j--)
                    hist[j] = hist[j - 1];
                hist[0] = 16'(k * 613 - 3000);
                sum = 0;
                for (int j = 0; j < cnts[c]; j++)
                    sum += hist[j];
                expq.push_back(16'(sum / cnts[c]));
                feed(1'b0, hist[0]);
            end
            stop_feed();
            repeat (6) @(posedge clk);
            check(32'(q.size()), 32'(cnts[c] + 2));
            foreach (expq[i])
                if (i < q.size())
                    check({16'h0000, q[i]}, {16'h0000, expq[i]});
            ahb_rd(`CFPC_STAT_IDX);
            check(rd, 32'h0000_0041 | 32'(cnts[c] << 1));
        end
        give_verdict();
    end
endmodule
